// ==== rtl/bridge_clock_rx_tx_config_regs.sv ====
// How it works
// - Output clock band is three bits, default 101; 110 and 111 reserved.
// - Pixel clock source bit: zero picks reference clock, one picks receive clock.
// - Five-bit divisor divides receive clock by code plus one; above 11000 reserved.
// - Two-bit factor multiplies reference clock by code plus one.
// - PLL turn-on bit enables PLL with clock settings; resets to zero.
// - Lane count code 00..11 selects four down to one lane; default 11.
// - Strict SoT bit zero tolerates one leader bit error; one tolerates none.
// - Two-bit equalization fields: 00 none, 01 1 dB, 11 2 dB, 10 reserved.
// - Receive clock band code in 5 MHz steps, 0x08 to 0x64 valid.
// - Data enable is high during active pixels unless invert bit is set.
// - Sync invert bits default one, driving syncs low while asserted.
// - Wide colour bit zero gives 18 bpp, fourth lane off; one gives 24 bpp.
// - Lane format picks two MSBs or two LSBs per colour on fourth lane.
// - Lane format one with narrow output drops the two LSBs per colour.
// - Pin reverse swaps lane 0 with lane 3 and lane 1 with clock.
// - Registers are read and written over the two-wire serial port.
`timescale 1ns/10ps
`default_nettype none
module bridge_clock_rx_tx_config_regs (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic addr_sel_i,
  input wire logic pll_running_i,
  input wire logic [23:0] pix_rgb_i,
  input wire logic pix_hsync_i,
  input wire logic pix_vsync_i,
  input wire logic pix_de_i,
  output logic pixclk_source_sel_o,
  output logic [2:0] out_clock_band_o,
  output logic [4:0] hs_clock_divisor_o,
  output logic [5:0] hs_divide_ratio_o,
  output logic [1:0] ref_clock_factor_o,
  output logic [2:0] ref_multiply_ratio_o,
  output logic pll_enable_o,
  output logic [1:0] rx_lane_count_o,
  output logic [2:0] rx_lanes_active_o,
  output logic strict_sot_check_o,
  output logic [1:0] rx_data_eq_o,
  output logic [1:0] rx_clock_eq_o,
  output logic [7:0] rx_clock_band_o,
  output logic config_reserved_o,
  output logic output_common_mode_sel_o,
  output logic [1:0] output_swing_sel_o,
  output logic output_termination_sel_o,
  output logic [1:0] common_mode_trim_o,
  output logic [6:0] pair0_word_o,
  output logic [6:0] pair1_word_o,
  output logic [6:0] pair2_word_o,
  output logic [6:0] out_lane3_pair_o,
  output logic [6:0] out_clock_pair_o,
  output logic lane3_enable_o
);
  import bridge_cfg_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic addr_s1;
    logic addr_s2;
    logic pll_s1;
    logic pll_s2;
    serial_state_t state;
    logic [2:0] bitcnt;
    logic byte_done;
    logic [7:0] shift;
    logic [7:0] subaddr;
    logic rw;
    logic master_ack;
    logic drive;
    logic src;
    logic [2:0] band;
    logic [4:0] div;
    logic [1:0] factor;
    logic pll_en;
    logic [1:0] lanes;
    logic sot;
    logic [1:0] deq;
    logic [1:0] ceq;
    logic [7:0] rx_band;
    logic de_inv;
    logic hs_inv;
    logic vs_inv;
    logic wide;
    logic fmt;
    logic vocm;
    logic [1:0] swing;
    logic rev;
    logic term;
    logic [1:0] cm;
  } regs_t;

  regs_t r_reg;
  regs_t r_next;

  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] rd_byte;

  // ==========================================================
  // Register read and write decode
  // Reserved bits and unlisted offsets read as zero
  function automatic logic [7:0] read_byte(input logic [7:0] a, input regs_t s);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      REG_CLK_SRC_BAND: begin
        d[POS_PLL_STAT] = s.pll_s2;
        d[POS_BAND_LSB +: 3] = s.band;
        d[POS_SRC] = s.src;
      end
      REG_CLK_DIV_MUL: begin
        d[POS_DIV_LSB +: 5] = s.div;
        d[POS_FACTOR_LSB +: 2] = s.factor;
      end
      REG_PLL_CTRL: d[POS_PLL_EN] = s.pll_en;
      REG_RX_LANE_CFG: begin
        d[POS_LANES_LSB +: 2] = s.lanes;
        d[POS_SOT] = s.sot;
      end
      REG_RX_EQ: begin
        d[POS_DEQ_LSB +: 2] = s.deq;
        d[POS_CEQ_LSB +: 2] = s.ceq;
      end
      REG_RX_CLK_BAND: d = s.rx_band;
      REG_OUT_FMT_POL: begin
        d[POS_DE_INV] = s.de_inv;
        d[POS_HS_INV] = s.hs_inv;
        d[POS_VS_INV] = s.vs_inv;
        d[POS_WIDE] = s.wide;
        d[POS_FMT] = s.fmt;
      end
      REG_OUT_DRIVE: begin
        d[POS_VOCM] = s.vocm;
        d[POS_SWING_LSB +: 2] = s.swing;
      end
      REG_OUT_ORDER_TERM: begin
        d[POS_REV] = s.rev;
        d[POS_TERM] = s.term;
      end
      REG_OUT_CM_TRIM: d[POS_CM_LSB +: 2] = s.cm;
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  // Only writable fields take data; reserved bits keep their value
  function automatic regs_t write_byte(input regs_t s, input logic [7:0] a,
                                       input logic [7:0] d);
    regs_t t;
    t = s;
    case (a)
      REG_CLK_SRC_BAND: begin
        t.band = d[POS_BAND_LSB +: 3];
        t.src = d[POS_SRC];
      end
      REG_CLK_DIV_MUL: begin
        t.div = d[POS_DIV_LSB +: 5];
        t.factor = d[POS_FACTOR_LSB +: 2];
      end
      REG_PLL_CTRL: t.pll_en = d[POS_PLL_EN];
      REG_RX_LANE_CFG: begin
        t.lanes = d[POS_LANES_LSB +: 2];
        t.sot = d[POS_SOT];
      end
      REG_RX_EQ: begin
        t.deq = d[POS_DEQ_LSB +: 2];
        t.ceq = d[POS_CEQ_LSB +: 2];
      end
      REG_RX_CLK_BAND: t.rx_band = d;
      REG_OUT_FMT_POL: begin
        t.de_inv = d[POS_DE_INV];
        t.hs_inv = d[POS_HS_INV];
        t.vs_inv = d[POS_VS_INV];
        t.wide = d[POS_WIDE];
        t.fmt = d[POS_FMT];
      end
      REG_OUT_DRIVE: begin
        t.vocm = d[POS_VOCM];
        t.swing = d[POS_SWING_LSB +: 2];
      end
      REG_OUT_ORDER_TERM: begin
        t.rev = d[POS_REV];
        t.term = d[POS_TERM];
      end
      REG_OUT_CM_TRIM: t.cm = d[POS_CM_LSB +: 2];
      default: t = s;
    endcase
    return t;
  endfunction

  // ==========================================================
  // Serial port slave
  // Edges are judged on the second and third synchroniser stages only,
  // so a metastable first-stage sample never reaches the state machine.
  always_comb begin
    r_next = r_reg;
    r_next.scl_s1 = scl_i;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_d = r_reg.scl_s2;
    r_next.sda_s1 = sda_i;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_d = r_reg.sda_s2;
    r_next.addr_s1 = addr_sel_i;
    r_next.addr_s2 = r_reg.addr_s1;
    r_next.pll_s1 = pll_running_i;
    r_next.pll_s2 = r_reg.pll_s1;
    start_seen = r_reg.scl_s2 && r_reg.scl_d && r_reg.sda_d && !r_reg.sda_s2;
    stop_seen = r_reg.scl_s2 && r_reg.scl_d && !r_reg.sda_d && r_reg.sda_s2;
    scl_rise = r_reg.scl_s2 && !r_reg.scl_d;
    scl_fall = !r_reg.scl_s2 && r_reg.scl_d;
    rd_byte = read_byte(r_reg.subaddr, r_reg);
    if (start_seen) begin
      // A repeated start also lands here
      r_next.state = ST_ADDR;
      r_next.bitcnt = 3'h0;
      r_next.byte_done = 1'b0;
      r_next.drive = 1'b0;
    end else if (stop_seen) begin
      r_next.state = ST_IDLE;
      r_next.drive = 1'b0;
    end else if (scl_rise) begin
      case (r_reg.state)
        ST_ADDR, ST_SUB, ST_WDATA: begin
          r_next.shift = {r_reg.shift[6:0], r_reg.sda_s2};
          r_next.bitcnt = r_reg.bitcnt + 3'h1;
          r_next.byte_done = (r_reg.bitcnt == 3'h7);
        end
        ST_RDATA: begin
          r_next.shift = {r_reg.shift[6:0], 1'b0};
          r_next.bitcnt = r_reg.bitcnt + 3'h1;
          r_next.byte_done = (r_reg.bitcnt == 3'h7);
        end
        ST_RACK: r_next.master_ack = !r_reg.sda_s2;
        default: r_next.master_ack = r_reg.master_ack;
      endcase
    end else if (scl_fall) begin
      case (r_reg.state)
        ST_ADDR: begin
          if (r_reg.byte_done) begin
            r_next.byte_done = 1'b0;
            if (r_reg.shift[7:1] == {DEV_ADDR_BASE, r_reg.addr_s2}) begin
              r_next.drive = 1'b1;
              r_next.rw = r_reg.shift[0];
              r_next.state = ST_AACK;
            end else begin
              r_next.state = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (r_reg.rw) begin
            // Reads resume at the subaddress last written, plus one for each data byte moved since
            r_next.shift = rd_byte;
            r_next.drive = !rd_byte[7];
            r_next.state = ST_RDATA;
          end else begin
            r_next.drive = 1'b0;
            r_next.state = ST_SUB;
          end
        end
        ST_SUB: begin
          if (r_reg.byte_done) begin
            r_next.byte_done = 1'b0;
            r_next.subaddr = r_reg.shift;
            r_next.drive = 1'b1;
            r_next.state = ST_SACK;
          end
        end
        ST_SACK: begin
          r_next.drive = 1'b0;
          r_next.state = ST_WDATA;
        end
        ST_WDATA: begin
          if (r_reg.byte_done) begin
            r_next.byte_done = 1'b0;
            r_next = write_byte(r_next, r_reg.subaddr, r_reg.shift);
            r_next.drive = 1'b1;
            r_next.state = ST_WACK;
          end
        end
        ST_WACK: begin
          r_next.drive = 1'b0;
          r_next.subaddr = r_reg.subaddr + 8'h01;
          r_next.state = ST_WDATA;
        end
        ST_RDATA: begin
          if (r_reg.byte_done) begin
            r_next.byte_done = 1'b0;
            r_next.drive = 1'b0;
            r_next.subaddr = r_reg.subaddr + 8'h01;
            r_next.state = ST_RACK;
          end else begin
            r_next.drive = !r_reg.shift[7];
          end
        end
        ST_RACK: begin
          if (r_reg.master_ack) begin
            r_next.shift = rd_byte;
            r_next.drive = !rd_byte[7];
            r_next.state = ST_RDATA;
          end else begin
            r_next.state = ST_IDLE;
          end
        end
        default: r_next.state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.scl_s1 <= 1'b1;
      r_reg.scl_s2 <= 1'b1;
      r_reg.scl_d <= 1'b1;
      r_reg.sda_s1 <= 1'b1;
      r_reg.sda_s2 <= 1'b1;
      r_reg.sda_d <= 1'b1;
      r_reg.state <= ST_IDLE;
      r_reg.src <= RST_SRC;
      r_reg.band <= RST_BAND;
      r_reg.div <= RST_DIV;
      r_reg.factor <= RST_FACTOR;
      r_reg.pll_en <= RST_PLL_EN;
      r_reg.lanes <= RST_LANES;
      r_reg.sot <= RST_SOT;
      r_reg.deq <= RST_EQ;
      r_reg.ceq <= RST_EQ;
      r_reg.rx_band <= RST_RX_BAND;
      r_reg.de_inv <= RST_DE_INV;
      r_reg.hs_inv <= RST_HS_INV;
      r_reg.vs_inv <= RST_VS_INV;
      r_reg.wide <= RST_WIDE;
      r_reg.fmt <= RST_FMT;
      r_reg.vocm <= RST_VOCM;
      r_reg.swing <= RST_SWING;
      r_reg.rev <= RST_REV;
      r_reg.term <= RST_TERM;
      r_reg.cm <= RST_CM;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs
  assign sda_o = 1'b0;
  assign sda_oe_n_o = !r_reg.drive;
  assign pixclk_source_sel_o = r_reg.src;
  assign out_clock_band_o = r_reg.band;
  assign hs_clock_divisor_o = r_reg.div;
  assign hs_divide_ratio_o = {1'b0, r_reg.div} + 6'h01;
  assign ref_clock_factor_o = r_reg.factor;
  assign ref_multiply_ratio_o = {1'b0, r_reg.factor} + 3'h1;
  // The PLL sees its settings at all times, enabled or not; host keeps them stable while enabled
  assign pll_enable_o = r_reg.pll_en;
  assign rx_lane_count_o = r_reg.lanes;
  assign rx_lanes_active_o = 3'h4 - {1'b0, r_reg.lanes};
  assign strict_sot_check_o = r_reg.sot;
  assign rx_data_eq_o = r_reg.deq;
  assign rx_clock_eq_o = r_reg.ceq;
  assign rx_clock_band_o = r_reg.rx_band;
  // Flags any reserved code held in the clock and receiver fields
  assign config_reserved_o = (r_reg.band > BAND_MAX) || (r_reg.div > DIV_MAX) ||
                             (r_reg.deq == EQ_RESERVED) || (r_reg.ceq == EQ_RESERVED) ||
                             (r_reg.rx_band < RX_BAND_MIN) ||
                             (r_reg.rx_band > RX_BAND_MAX);
  assign output_common_mode_sel_o = r_reg.vocm;
  assign output_swing_sel_o = r_reg.swing;
  assign output_termination_sel_o = r_reg.term;
  assign common_mode_trim_o = r_reg.cm;

  // ==========================================================
  // Output lane mapping
  output_lane_mapper u_map (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pix_rgb_i(pix_rgb_i),
    .pix_hsync_i(pix_hsync_i),
    .pix_vsync_i(pix_vsync_i),
    .pix_de_i(pix_de_i),
    .data_enable_invert_i(r_reg.de_inv),
    .hsync_invert_i(r_reg.hs_inv),
    .vsync_invert_i(r_reg.vs_inv),
    .wide_colour_output_i(r_reg.wide),
    .lane_format_select_i(r_reg.fmt),
    .output_pin_reverse_i(r_reg.rev),
    .pair0_word_o(pair0_word_o),
    .pair1_word_o(pair1_word_o),
    .pair2_word_o(pair2_word_o),
    .out_lane3_pair_o(out_lane3_pair_o),
    .out_clock_pair_o(out_clock_pair_o),
    .lane3_enable_o(lane3_enable_o)
  );

endmodule
`default_nettype wire

// ==== include/bridge_cfg_pkg.sv ====
package bridge_cfg_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] REG_CLK_SRC_BAND = 8'h0A;
  localparam logic [7:0] REG_CLK_DIV_MUL = 8'h0B;
  localparam logic [7:0] REG_PLL_CTRL = 8'h0D;
  localparam logic [7:0] REG_RX_LANE_CFG = 8'h10;
  localparam logic [7:0] REG_RX_EQ = 8'h11;
  localparam logic [7:0] REG_RX_CLK_BAND = 8'h12;
  localparam logic [7:0] REG_OUT_FMT_POL = 8'h18;
  localparam logic [7:0] REG_OUT_DRIVE = 8'h19;
  localparam logic [7:0] REG_OUT_ORDER_TERM = 8'h1A;
  localparam logic [7:0] REG_OUT_CM_TRIM = 8'h1B;

  // ==========================================================
  // Field positions
  localparam int POS_PLL_STAT = 7;
  localparam int POS_BAND_LSB = 1;
  localparam int POS_SRC = 0;
  localparam int POS_DIV_LSB = 3;
  localparam int POS_FACTOR_LSB = 0;
  localparam int POS_PLL_EN = 0;
  localparam int POS_LANES_LSB = 3;
  localparam int POS_SOT = 0;
  localparam int POS_DEQ_LSB = 6;
  localparam int POS_CEQ_LSB = 2;
  localparam int POS_DE_INV = 7;
  localparam int POS_HS_INV = 6;
  localparam int POS_VS_INV = 5;
  localparam int POS_WIDE = 3;
  localparam int POS_FMT = 1;
  localparam int POS_VOCM = 6;
  localparam int POS_SWING_LSB = 2;
  localparam int POS_REV = 5;
  localparam int POS_TERM = 1;
  localparam int POS_CM_LSB = 4;

  // ==========================================================
  // Reset values
  localparam logic RST_SRC = 1'b0;
  localparam logic [2:0] RST_BAND = 3'h5;
  localparam logic [4:0] RST_DIV = 5'h00;
  localparam logic [1:0] RST_FACTOR = 2'h0;
  localparam logic RST_PLL_EN = 1'b0;
  localparam logic [1:0] RST_LANES = 2'h3;
  localparam logic RST_SOT = 1'b0;
  localparam logic [1:0] RST_EQ = 2'h0;
  localparam logic [7:0] RST_RX_BAND = 8'h00;
  localparam logic RST_DE_INV = 1'b0;
  localparam logic RST_HS_INV = 1'b1;
  localparam logic RST_VS_INV = 1'b1;
  localparam logic RST_WIDE = 1'b0;
  localparam logic RST_FMT = 1'b0;
  localparam logic RST_VOCM = 1'b0;
  localparam logic [1:0] RST_SWING = 2'h1;
  localparam logic RST_REV = 1'b0;
  localparam logic RST_TERM = 1'b1;
  localparam logic [1:0] RST_CM = 2'h0;

  // ==========================================================
  // Code limits
  localparam logic [2:0] BAND_MAX = 3'h5;
  localparam logic [4:0] DIV_MAX = 5'h18;
  localparam logic [1:0] EQ_RESERVED = 2'h2;
  localparam logic [7:0] RX_BAND_MIN = 8'h08;
  localparam logic [7:0] RX_BAND_MAX = 8'h64;

  // Upper six bits of the serial port address; the pin sets bit 0
  localparam logic [5:0] DEV_ADDR_BASE = 6'h16;

  localparam logic [6:0] CLK_PAIR_WORD = 7'h63;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h2,
    ST_SUB = 4'h3,
    ST_SACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h8
  } serial_state_t;

endpackage

// ==== rtl/output_lane_mapper.sv ====
`timescale 1ns/10ps
`default_nettype none
module output_lane_mapper (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [23:0] pix_rgb_i,
  input wire logic pix_hsync_i,
  input wire logic pix_vsync_i,
  input wire logic pix_de_i,
  input wire logic data_enable_invert_i,
  input wire logic hsync_invert_i,
  input wire logic vsync_invert_i,
  input wire logic wide_colour_output_i,
  input wire logic lane_format_select_i,
  input wire logic output_pin_reverse_i,
  output logic [6:0] pair0_word_o,
  output logic [6:0] pair1_word_o,
  output logic [6:0] pair2_word_o,
  output logic [6:0] out_lane3_pair_o,
  output logic [6:0] out_clock_pair_o,
  output logic lane3_enable_o
);
  import bridge_cfg_pkg::*;

  typedef struct packed {
    logic [6:0] p0;
    logic [6:0] p1;
    logic [6:0] p2;
    logic [6:0] p3;
    logic [6:0] pc;
    logic en3;
  } map_t;

  map_t r_reg;
  map_t r_next;

  logic [7:0] red;
  logic [7:0] grn;
  logic [7:0] blu;
  logic [5:0] r6;
  logic [5:0] g6;
  logic [5:0] b6;
  logic [1:0] rx;
  logic [1:0] gx;
  logic [1:0] bx;
  logic hs;
  logic vs;
  logic de;
  logic [6:0] l0;
  logic [6:0] l1;
  logic [6:0] l2;
  logic [6:0] l3;

  // ==========================================================
  // Lane packing
  always_comb begin
    red = pix_rgb_i[23:16];
    grn = pix_rgb_i[15:8];
    blu = pix_rgb_i[7:0];
    // Narrow output drops the two low bits per colour when lane format picks them
    r6 = lane_format_select_i ? red[7:2] : red[5:0];
    g6 = lane_format_select_i ? grn[7:2] : grn[5:0];
    b6 = lane_format_select_i ? blu[7:2] : blu[5:0];
    rx = lane_format_select_i ? red[1:0] : red[7:6];
    gx = lane_format_select_i ? grn[1:0] : grn[7:6];
    bx = lane_format_select_i ? blu[1:0] : blu[7:6];
    de = pix_de_i ^ data_enable_invert_i;
    hs = pix_hsync_i ^ hsync_invert_i;
    vs = pix_vsync_i ^ vsync_invert_i;
    l0 = {g6[0], r6};
    l1 = {b6[1:0], g6[5:1]};
    l2 = {de, vs, hs, b6[5:2]};
    // Fourth lane idles low in narrow mode
    l3 = wide_colour_output_i ? {1'b0, bx, gx, rx} : 7'h00;
    r_next.en3 = wide_colour_output_i;
    r_next.p2 = l2;
    if (output_pin_reverse_i) begin
      r_next.p0 = l3;
      r_next.p3 = l0;
      r_next.p1 = CLK_PAIR_WORD;
      r_next.pc = l1;
    end else begin
      r_next.p0 = l0;
      r_next.p3 = l3;
      r_next.p1 = l1;
      r_next.pc = CLK_PAIR_WORD;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pair0_word_o = r_reg.p0;
  assign pair1_word_o = r_reg.p1;
  assign pair2_word_o = r_reg.p2;
  assign out_lane3_pair_o = r_reg.p3;
  assign out_clock_pair_o = r_reg.pc;
  assign lane3_enable_o = r_reg.en3;

endmodule
`default_nettype wire

// ==== dv/host_i2c_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Two-wire host, SDA released to the pull-up
module host_i2c_model (
  input wire logic sys_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  logic [6:0] dev;
  logic nack;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    dev = 7'h2C;
    nack = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // Phases of 8 clocks stay well clear of the 4-clock minimum
  task automatic bo(input logic b);
    sda_o = b;
    tk(2);
    scl_o = 1'b1;
    tk(8);
    scl_o = 1'b0;
    tk(6);
  endtask
  task automatic bi(output logic b);
    sda_o = 1'b1;
    tk(2);
    scl_o = 1'b1;
    tk(4);
    b = sda_i;
    tk(4);
    scl_o = 1'b0;
    tk(6);
  endtask
  task automatic st;
    bo(1'b1);
    sda_o = 1'b1;
    scl_o = 1'b1;
    tk(8);
    sda_o = 1'b0;
    tk(8);
    scl_o = 1'b0;
    tk(6);
  endtask
  task automatic sp;
    sda_o = 1'b0;
    tk(2);
    scl_o = 1'b1;
    tk(8);
    sda_o = 1'b1;
    tk(8);
  endtask
  task automatic wb(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) bo(d[i]);
    bi(a);
    nack = nack | a;
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    st();
    wb({dev, 1'b0});
    wb(sub);
    wb(d);
    sp();
  endtask
  task automatic rd(input logic [7:0] sub, output logic [7:0] d);
    st();
    wb({dev, 1'b0});
    wb(sub);
    st();
    wb({dev, 1'b1});
    for (int i = 7; i >= 0; i--) bi(d[i]);
    bo(1'b1);
    sp();
  endtask
endmodule
`default_nettype wire

// ==== dv/bridge_cfg_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module bridge_cfg_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic pixclk_source_sel_o,
  input wire logic [2:0] out_clock_band_o,
  input wire logic [4:0] hs_clock_divisor_o,
  input wire logic [5:0] hs_divide_ratio_o,
  input wire logic [1:0] ref_clock_factor_o,
  input wire logic [2:0] ref_multiply_ratio_o,
  input wire logic pll_enable_o,
  input wire logic [1:0] rx_lane_count_o,
  input wire logic [2:0] rx_lanes_active_o,
  input wire logic strict_sot_check_o,
  input wire logic [1:0] rx_data_eq_o,
  input wire logic [1:0] rx_clock_eq_o,
  input wire logic [7:0] rx_clock_band_o,
  input wire logic config_reserved_o,
  input wire logic [6:0] pair1_word_o,
  input wire logic [6:0] out_clock_pair_o,
  input wire logic lane3_enable_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  a_div_ratio: assert property (hs_divide_ratio_o == {1'b0, hs_clock_divisor_o} + 6'h1)
    else $error("divide ratio wrong");
  a_mul_ratio: assert property (ref_multiply_ratio_o == {1'b0, ref_clock_factor_o} + 3'h1)
    else $error("multiply ratio wrong");
  a_lanes_on: assert property (rx_lanes_active_o == 3'h4 - {1'b0, rx_lane_count_o})
    else $error("active lane count wrong");
  a_resv_flag: assert property (config_reserved_o == (out_clock_band_o > 3'h5 ||
    hs_clock_divisor_o > 5'h18 || rx_data_eq_o == 2'h2 || rx_clock_eq_o == 2'h2 ||
    rx_clock_band_o < 8'h08 || rx_clock_band_o > 8'h64)) else $error("reserved flag wrong");
  a_reset_dflt: assert property ($past(rst_i) |-> out_clock_band_o == 3'h5 &&
    hs_clock_divisor_o == 5'h00 && ref_clock_factor_o == 2'h0 && !pll_enable_o &&
    rx_lane_count_o == 2'h3 && !strict_sot_check_o && !pixclk_source_sel_o)
    else $error("defaults wrong after reset");
  a_pll_by_ack: assert property ($changed(pll_enable_o) |-> ##[0:4] !sda_oe_n_o)
    else $error("turn-on changed outside a write");
  a_oe_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("data line moved while clock high");
  a_sda_low: assert property (sda_o == 1'b0)
    else $error("data value not low");
  a_clock_word: assert property (!$past(rst_i) |->
    (out_clock_pair_o == 7'h63 || pair1_word_o == 7'h63)) else $error("clock word lost");
  c_pll_on: cover property ($rose(pll_enable_o));
  c_resv_clear: cover property ($fell(config_reserved_o));
  c_wide_on: cover property ($rose(lane3_enable_o));
endmodule
bind bridge_clock_rx_tx_config_regs bridge_cfg_chk chk (.*);
`default_nettype wire

// ==== dv/bridge_clock_rx_tx_config_regs_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK_EQ(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %0t: got %0h want %0h", $time, g, e); end end
module bridge_clock_rx_tx_config_regs_tb;
  import bridge_cfg_pkg::*;
  logic sys_clk_i, rst_i, scl_i, sda_h, addr_sel_i, pll_running_i, pix_hsync_i, pix_vsync_i;
  logic pix_de_i, sda_o, sda_oe_n_o, pixclk_source_sel_o, pll_enable_o, strict_sot_check_o;
  logic config_reserved_o, lane3_enable_o, output_common_mode_sel_o, output_termination_sel_o;
  logic [23:0] pix_rgb_i;
  logic [1:0] ref_clock_factor_o, rx_lane_count_o, rx_data_eq_o, rx_clock_eq_o;
  logic [1:0] output_swing_sel_o, common_mode_trim_o;
  logic [2:0] out_clock_band_o, ref_multiply_ratio_o, rx_lanes_active_o;
  logic [4:0] hs_clock_divisor_o;
  logic [5:0] hs_divide_ratio_o;
  logic [6:0] pair0_word_o, pair1_word_o, pair2_word_o, out_lane3_pair_o, out_clock_pair_o;
  logic [7:0] rx_clock_band_o, d;
  logic [7:0] v [11];
  logic [7:0] ofs [11] = '{8'h0A, 8'h0B, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h18, 8'h19, 8'h1A,
    8'h1B, 8'h05};
  logic [7:0] msk [11] = '{8'h0F, 8'hFB, 8'h01, 8'h19, 8'hCC, 8'hFF, 8'hEA, 8'h4C, 8'h22,
    8'h30, 8'h00};
  logic [7:0] rstv [11] = '{8'h0A, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h60, 8'h04, 8'h02,
    8'h00, 8'h00};
  logic [7:0] cofs [11] = '{8'h12, 8'h0A, 8'h0A, 8'h0B, 8'h0B, 8'h11, 8'h11, 8'h11, 8'h12,
    8'h12, 8'h12};
  logic [7:0] cval [11] = '{8'h08, 8'h0C, 8'h0B, 8'hC8, 8'hC0, 8'h80, 8'h08, 8'hCC, 8'h07,
    8'h65, 8'h64};
  logic [10:0] cflg = 11'b01101101010;
  logic [31:0] seed = 32'd91;
  int error_cnt = 0;
  int checked = 0;
  wire sda_i = sda_oe_n_o & sda_h;
  bridge_clock_rx_tx_config_regs uut (.*);
  host_i2c_model host (.sys_clk_i(sys_clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_o(sda_h));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Status bit in the first register follows the PLL input, not the write
  function automatic logic [7:0] exp_rd(input int i, input logic [7:0] w);
    return (w & msk[i]) | ((i == 0 && pll_running_i) ? 8'h80 : 8'h00);
  endfunction
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (95000) @(posedge sys_clk_i);
    error_cnt++;
    wrap_up();
  end
  // ==========================================
  // Main sequence
  initial begin
    rst_i = 1'b1;
    addr_sel_i = 1'b0;
    pll_running_i = 1'b0;
    {pix_rgb_i, pix_hsync_i, pix_vsync_i, pix_de_i} = 27'h0;
    repeat (5) @(negedge sys_clk_i);
    rst_i = 1'b0;
    host.tk(4);
    for (int i = 0; i < 11; i++) begin
      host.rd(ofs[i], d);
      `CHK_EQ(d, exp_rd(i, rstv[i]))
    end
    `CHK_EQ(config_reserved_o, 1'b1)
    done("reset values");
    for (int i = 0; i < 11; i++) begin
      host.wr(cofs[i], cval[i]);
      `CHK_EQ(config_reserved_o, cflg[i])
    end
    done("reserved codes");
    host.dev = 7'h2D;
    host.wr(8'h12, 8'h33);
    host.dev = 7'h2C;
    `CHK_EQ(host.nack, 1'b1)
    host.nack = 1'b0;
    host.rd(8'h12, d);
    `CHK_EQ(d, 8'h64)
    pll_running_i = 1'b1;
    host.wr(8'h0D, 8'h01);
    `CHK_EQ(pll_enable_o, 1'b1)
    host.rd(8'h0A, d);
    `CHK_EQ(d[7], 1'b1)
    done("address and pll");
    repeat (2) begin
      host.wr(8'h0D, 8'h00);
      for (int i = 0; i < 11; i++) begin
        v[i] = 8'(rnd()) & msk[i];
        if (i == 1) v[1] &= v[0][0] ? 8'hF8 : 8'h03;
        host.wr(ofs[i], v[i]);
      end
      host.wr(8'h09, 8'h01);
      for (int i = 0; i < 11; i++) begin
        host.rd(ofs[i], d);
        `CHK_EQ(d, exp_rd(i, v[i]))
      end
      `CHK_EQ({pixclk_source_sel_o, strict_sot_check_o}, {v[0][0], v[3][0]})
      `CHK_EQ(rx_lanes_active_o, 3'h4 - {1'b0, v[3][4:3]})
      `CHK_EQ({output_swing_sel_o, common_mode_trim_o}, {v[7][3:2], v[9][5:4]})
      `CHK_EQ({output_common_mode_sel_o, output_termination_sel_o}, {v[7][6], v[8][1]})
      `CHK_EQ(host.nack, 1'b0)
    end
    done("random registers");
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h18, {k[0], k[1], ~k[0], 1'b0, k[1], 1'b0, k[0], 1'b0});
      host.wr(8'h1A, {2'b00, k == 3, 3'b000, 2'b10});
      repeat (8) begin
        {pix_rgb_i, pix_hsync_i, pix_vsync_i, pix_de_i} = 27'(rnd());
        @(negedge sys_clk_i);
        `CHK_EQ(pair2_word_o[6:4], {pix_de_i ^ k[0], pix_vsync_i ^ ~k[0], pix_hsync_i ^ k[1]})
        `CHK_EQ(lane3_enable_o, k[1])
        `CHK_EQ(k == 3 ? pair1_word_o : out_clock_pair_o, CLK_PAIR_WORD)
        if (k < 2) `CHK_EQ(out_lane3_pair_o, 7'h00)
        if (k == 1) `CHK_EQ(pair0_word_o, {pix_rgb_i[10], pix_rgb_i[23:18]})
        if (k != 1 && k != 3) `CHK_EQ(pair0_word_o, {pix_rgb_i[8], pix_rgb_i[21:16]})
        if (k == 3) `CHK_EQ(pair0_word_o, {1'b0, pix_rgb_i[1:0], pix_rgb_i[9:8], pix_rgb_i[17:16]})
      end
    end
    done("pixel path");
    wrap_up();
  end
endmodule
`default_nettype wire
